// file: verilog/rfpmsc_pkg.sv
// constants and types for the rf port mode and switch control block
package rfpmsc_pkg;
   // serial frame layout: command byte then one 16-bit data word, msb first
   localparam int unsigned CMD_BITS = 8;
   localparam int unsigned DATA_BITS = 16;
   localparam int unsigned FRAME_BITS = CMD_BITS + DATA_BITS;
   localparam int unsigned CMD_READ_POS = 7;
   localparam int unsigned ADDR_BITS = 6;
   localparam logic [4:0] BIT_CNT_CMD_END = 5'h07;
   localparam logic [4:0] BIT_CNT_FRAME_END = 5'h17;

   // register map
   localparam logic [5:0] RF_IF_CTRL_ADDR = 6'h07;
   localparam logic [5:0] RF_STATUS_ADDR = 6'h08;

   // field positions in rf_interface_control_reg
   localparam int unsigned PORT_MODE_SEL_POS = 12;
   localparam int unsigned CTRL_OUT_POL_POS = 13;
   localparam int unsigned CTRL_OUT_EN_POS = 14;

   // reset value and value read at unmapped addresses
   localparam logic [15:0] RF_IF_CTRL_RESET = 16'h0000;
   localparam logic [15:0] RD_UNMAPPED = 16'h0000;

   // field positions in the status word
   localparam int unsigned STAT_STATE_LSB = 0;
   localparam int unsigned STAT_CTRL_OUT_POS = 4;
   localparam int unsigned STAT_CTRL_OE_POS = 5;
   localparam int unsigned STAT_LNA_SW_POS = 6;
   localparam int unsigned STAT_SHARED_PA_POS = 7;
   localparam int unsigned STAT_TX_PA_POS = 8;
   localparam int unsigned STAT_BIDIR_POS = 9;

   typedef enum logic [2:0]
   {
      RFPMSC_ST_IDLE = 3'b000,
      RFPMSC_ST_DOZE = 3'b001,
      RFPMSC_ST_HIBERNATE = 3'b010,
      RFPMSC_ST_CCA = 3'b011,
      RFPMSC_ST_RX = 3'b100,
      RFPMSC_ST_TX = 3'b101
   } rfpmsc_radio_state_t;
endpackage

// file: verilog/rfpmsc_serial_if.sv
// serial register port: frames a command byte and a 16-bit word
`timescale 1ns/10ps
`default_nettype none
module rfpmsc_serial_if
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // serial pins, sampled on clk_sys
   input wire logic ce_n,
   input wire logic sclk,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   // register side
   output logic [5:0] reg_addr,
   output logic reg_wr,
   output logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata
);
   import rfpmsc_pkg::*;

   logic sclk_r;
   logic [4:0] bit_cnt_r;
   logic [23:0] shift_r;
   logic is_read_r;
   logic [15:0] out_r;
   logic rise;
   logic fall;

   assign rise = sclk & ~sclk_r & ~ce_n;
   assign fall = ~sclk & sclk_r & ~ce_n;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         sclk_r <= 1'b0;
      else
         sclk_r <= sclk;
   end

   // bit counting and input shifting on rising sclk
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bit_cnt_r <= 5'h00;
         shift_r <= 24'h000000;
         is_read_r <= 1'b0;
         reg_addr <= 6'h00;
         reg_wr <= 1'b0;
         reg_wdata <= 16'h0000;
      end
      else
      begin
         reg_wr <= 1'b0;
         if (ce_n)
            bit_cnt_r <= 5'h00;
         else if (rise)
         begin
            shift_r <= {shift_r[22:0], mosi};
            if (bit_cnt_r == BIT_CNT_CMD_END)
            begin
               is_read_r <= shift_r[CMD_READ_POS - 1];
               reg_addr <= {shift_r[ADDR_BITS - 2:0], mosi};
            end
            if (bit_cnt_r == BIT_CNT_FRAME_END)
            begin
               bit_cnt_r <= 5'h00;
               reg_wr <= ~is_read_r;
               reg_wdata <= {shift_r[DATA_BITS - 2:0], mosi};
            end
            else
               bit_cnt_r <= bit_cnt_r + 5'h01;
         end
      end
   end

   // read data: loaded after the command byte, shifted out on falling sclk
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_r <= 16'h0000;
         miso <= 1'b0;
      end
      else if (ce_n)
         miso <= 1'b0;
      else if (fall)
      begin
         if (bit_cnt_r == 5'h08 && is_read_r)
         begin
            miso <= reg_rdata[15];
            out_r <= {reg_rdata[14:0], 1'b0};
         end
         else
         begin
            miso <= out_r[15];
            out_r <= {out_r[14:0], 1'b0};
         end
      end
   end

   assign miso_oe = ~ce_n;
endmodule // rfpmsc_serial_if
`default_nettype wire

// file: verilog/rfpmsc_top.sv
// rf port mode selection and switch control output with its control register
`timescale 1ns/10ps
`default_nettype none
// Function
// - port mode bit clear (reset) selects dual-port, set selects single-port
// - dual-port: receive pair input only, lna switch on for receive, its pa off
// - dual-port: transmit pair is the output, its pa on while transmitting
// - single-port: internal switch active, shared pair carries transmit and receive
// - enable bit clear (reset): control output tristated in every state
// - enabled: level follows port mode, then transmit or receive activity
// - polarity bit (reset zero) matters only in dual-port with output enabled
// - single-port enabled: high on transmit, low on receive, polarity ignored
// - dual-port enabled: opposite levels for tx and rx, polarity swaps them
// - output defined in idle, hibernate, doze, transmit and receive
// - output high only during cca, receive or transmit sequences
module rfpmsc_top
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // serial register port
   input wire logic ce_n,
   input wire logic sclk,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   // radio sequencer state
   input wire rfpmsc_pkg::rfpmsc_radio_state_t radio_state,
   // switch control pin
   output logic rf_ctrl_out,
   output logic rf_ctrl_out_oe,
   // rf path controls
   output logic lna_rx_switch_en,
   output logic shared_pair_pa_en,
   output logic tx_pair_pa_en,
   output logic shared_pair_bidir,
   // register bits for observation
   output logic port_mode_sel,
   output logic rf_ctrl_out_enable,
   output logic rf_ctrl_out_polarity
);
   import rfpmsc_pkg::*;

   logic rst_meta_r;
   logic rst_n_r;
   logic [5:0] reg_addr;
   logic reg_wr;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic [15:0] rf_interface_control_reg_r;
   logic [15:0] status_word;
   logic ctrl_out_nxt;
   logic lna_nxt;
   logic shared_pa_nxt;
   logic tx_pa_nxt;

   function automatic logic seq_active(input rfpmsc_radio_state_t st);
      seq_active = (st == RFPMSC_ST_CCA) || (st == RFPMSC_ST_RX) || (st == RFPMSC_ST_TX);
   endfunction

   function automatic logic listening(input rfpmsc_radio_state_t st);
      listening = (st == RFPMSC_ST_CCA) || (st == RFPMSC_ST_RX);
   endfunction

   // reset release through two flops
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   rfpmsc_serial_if u_serial
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n_r),
      .ce_n(ce_n),
      .sclk(sclk),
      .mosi(mosi),
      .miso(miso),
      .miso_oe(miso_oe),
      .reg_addr(reg_addr),
      .reg_wr(reg_wr),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata)
   );

   // control register; new bits act from the write onward
   always_ff @(posedge clk_sys or negedge rst_n_r)
   begin
      if (!rst_n_r)
         rf_interface_control_reg_r <= RF_IF_CTRL_RESET;
      else if (reg_wr && reg_addr == RF_IF_CTRL_ADDR)
         rf_interface_control_reg_r <= reg_wdata;
   end

   assign port_mode_sel = rf_interface_control_reg_r[PORT_MODE_SEL_POS];
   assign rf_ctrl_out_enable = rf_interface_control_reg_r[CTRL_OUT_EN_POS];
   assign rf_ctrl_out_polarity = rf_interface_control_reg_r[CTRL_OUT_POL_POS];

   // control output level
   always_comb
   begin
      ctrl_out_nxt = 1'b0;
      if (!seq_active(radio_state))
         ctrl_out_nxt = 1'b0;
      else if (port_mode_sel)
         ctrl_out_nxt = (radio_state == RFPMSC_ST_TX);
      else
         ctrl_out_nxt = (radio_state == RFPMSC_ST_TX) ^ rf_ctrl_out_polarity;
   end

   always_ff @(posedge clk_sys or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         rf_ctrl_out <= 1'b0;
         rf_ctrl_out_oe <= 1'b0;
      end
      else
      begin
         rf_ctrl_out_oe <= rf_ctrl_out_enable;
         rf_ctrl_out <= rf_ctrl_out_enable & ctrl_out_nxt;
      end
   end

   // rf path selection
   always_comb
   begin
      lna_nxt = listening(radio_state);
      shared_pa_nxt = 1'b0;
      tx_pa_nxt = 1'b0;
      if (port_mode_sel)
         shared_pa_nxt = (radio_state == RFPMSC_ST_TX);
      else
         tx_pa_nxt = (radio_state == RFPMSC_ST_TX);
   end

   always_ff @(posedge clk_sys or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         lna_rx_switch_en <= 1'b0;
         shared_pair_pa_en <= 1'b0;
         tx_pair_pa_en <= 1'b0;
         shared_pair_bidir <= 1'b0;
      end
      else
      begin
         lna_rx_switch_en <= lna_nxt;
         shared_pair_pa_en <= shared_pa_nxt;
         tx_pair_pa_en <= tx_pa_nxt;
         shared_pair_bidir <= port_mode_sel;
      end
   end

   // read-back
   always_comb
   begin
      status_word = 16'h0000;
      status_word[STAT_STATE_LSB +: 3] = radio_state;
      status_word[STAT_CTRL_OUT_POS] = rf_ctrl_out;
      status_word[STAT_CTRL_OE_POS] = rf_ctrl_out_oe;
      status_word[STAT_LNA_SW_POS] = lna_rx_switch_en;
      status_word[STAT_SHARED_PA_POS] = shared_pair_pa_en;
      status_word[STAT_TX_PA_POS] = tx_pair_pa_en;
      status_word[STAT_BIDIR_POS] = shared_pair_bidir;
      case (reg_addr)
         RF_IF_CTRL_ADDR: reg_rdata = rf_interface_control_reg_r;
         RF_STATUS_ADDR: reg_rdata = status_word;
         default: reg_rdata = RD_UNMAPPED;
      endcase
   end
endmodule // rfpmsc_top
`default_nettype wire

// file: tb/rfpmsc_chk_assertions.sv
// port assertions for rfpmsc_top
`timescale 1ns/10ps
`default_nettype none
module rfpmsc_chk
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // watched ports
   input wire rfpmsc_pkg::rfpmsc_radio_state_t radio_state,
   input wire logic rf_ctrl_out,
   input wire logic rf_ctrl_out_oe,
   input wire logic lna_rx_switch_en,
   input wire logic shared_pair_pa_en,
   input wire logic tx_pair_pa_en,
   input wire logic port_mode_sel,
   input wire logic rf_ctrl_out_enable,
   input wire logic rf_ctrl_out_polarity
);
   import rfpmsc_pkg::*;
   logic [2:0] up_r;
   logic tx, rxs, act;
   assign tx = radio_state == RFPMSC_ST_TX;
   assign rxs = radio_state inside {RFPMSC_ST_CCA, RFPMSC_ST_RX};
   assign act = tx | rxs;
   // skips the two-flop reset release
   always_ff @(posedge clk_sys or negedge resetn)
      if (!resetn) up_r <= 3'h0;
      else if (!up_r[2]) up_r <= up_r + 3'h1;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   oe_enable_a: assert property (up_r[2] |-> rf_ctrl_out_oe == $past(rf_ctrl_out_enable))
      else $error("oe");
   idle_low_a: assert property (up_r[2] && $past(rf_ctrl_out_enable && !act) |-> !rf_ctrl_out)
      else $error("idle");
   single_level_a: assert property (up_r[2] && $past(rf_ctrl_out_enable && port_mode_sel) |->
      rf_ctrl_out == $past(tx)) else $error("single");
   dual_level_a: assert property (up_r[2] && $past(rf_ctrl_out_enable && !port_mode_sel && act)
      |-> rf_ctrl_out == $past(tx ^ rf_ctrl_out_polarity)) else $error("dual");
   active_high_a: assert property (up_r[2] && rf_ctrl_out |-> $past(act && rf_ctrl_out_enable))
      else $error("high");
   lna_path_a: assert property (up_r[2] |-> lna_rx_switch_en == $past(rxs)) else $error("lna");
   tx_pa_a: assert property (up_r[2] |-> tx_pair_pa_en == $past(tx && !port_mode_sel))
      else $error("txpa");
   shared_pa_a: assert property (up_r[2] |-> shared_pair_pa_en == $past(tx && port_mode_sel))
      else $error("shpa");
endmodule // rfpmsc_chk
bind rfpmsc_top rfpmsc_chk chk_u (.clk_sys, .resetn, .radio_state, .rf_ctrl_out, .rf_ctrl_out_oe, .lna_rx_switch_en,
   .shared_pair_pa_en, .tx_pair_pa_en, .port_mode_sel, .rf_ctrl_out_enable, .rf_ctrl_out_polarity);
`default_nettype wire

// file: tb/rfpmsc_ant_sw.sv
// external antenna switch on the control pin
`timescale 1ns/10ps
`default_nettype none
module rfpmsc_ant_sw
(
   // pin, pulled low on board
   input wire logic ctrl_pin,
   // selected path
   output logic tx_sel
);
   // floating pin reads as receive
   assign tx_sel = ctrl_pin === 1'b1;
endmodule // rfpmsc_ant_sw
`default_nettype wire

// file: tb/rf_port_mode_and_switch_ctrl_tb.sv
// self-checking bench for rfpmsc_top
`timescale 1ns/10ps
`default_nettype none
module rf_port_mode_and_switch_ctrl_tb;
   import rfpmsc_pkg::*;
   logic clk_sys = 0, resetn = 0, ce_n = 1, sclk = 0, mosi = 0, pin_v = 0, word_v = 0;
   rfpmsc_radio_state_t radio_state = RFPMSC_ST_IDLE;
   logic miso, miso_oe, oe, out, lna, shpa, txpa, bidir, mode, en, pol, tx_sel;
   logic [1:0] sel_seen;
   tri0 ctrl_pin;
   logic [31:0] seed = 32'h15;
   logic [15:0] got, pin_w, exp_word[$], exp_sel[$];
   logic [9:0] exp_pin[$];
   int miscompares = 0, comparisons = 0, cycles = 0;
   assign ctrl_pin = oe ? out : 1'bz;
   assign pin_w = {6'h00, oe, out, lna, shpa, txpa, bidir, mode, en, pol, tx_sel};
   always #2 clk_sys = ~clk_sys;
   rfpmsc_top dut_u (.clk_sys, .resetn, .ce_n, .sclk, .mosi, .miso, .miso_oe, .radio_state, .rf_ctrl_out(out),
      .rf_ctrl_out_oe(oe), .lna_rx_switch_en(lna), .shared_pair_pa_en(shpa), .tx_pair_pa_en(txpa),
      .shared_pair_bidir(bidir), .port_mode_sel(mode), .rf_ctrl_out_enable(en), .rf_ctrl_out_polarity(pol));
   rfpmsc_ant_sw sw_u (.ctrl_pin, .tx_sel);
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic test_done;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction
   // c = {enable, polarity, mode}
   function automatic logic [9:0] pins(input logic [2:0] c, input rfpmsc_radio_state_t s);
      logic tx, act, o;
      tx = s == RFPMSC_ST_TX;
      act = tx | s == RFPMSC_ST_RX | s == RFPMSC_ST_CCA;
      o = c[2] & act & (c[0] ? tx : tx ^ c[1]);
      return {c[2], o, act & !tx, c[0] & tx, !c[0] & tx, c[0], c[0], c[2], c[1], o};
   endfunction
   // msb-first frame, aborted early when nbits < 24
   task automatic frame(input logic [23:0] f, input int nbits, output logic [15:0] rd);
      ce_n = 0;
      for (int i = 23; i > 23 - nbits; i--)
      begin
         sclk = 0;
         mosi = f[i];
         tick(2);
         if (i < 16) rd[i] = miso;
         sclk = 1;
         tick(2);
      end
      sclk = 0;
      tick(4);
      sel_seen[1] = miso_oe;
      ce_n = 1;
      tick(2);
      sel_seen[0] = miso_oe;
   endtask
   task automatic rd_chk(input logic [5:0] a, input logic [15:0] e);
      exp_word.push_back(e);
      exp_sel.push_back(16'h0002);
      frame({2'b10, a, 16'h0000}, 24, got);
      word_v = 1;
      tick(1);
      word_v = 0;
   endtask
   task automatic pin_chk(input logic [2:0] c);
      logic [9:0] p;
      logic [15:0] st;
      for (int s = 0; s < 6; s++)
      begin
         radio_state = rfpmsc_radio_state_t'(s[2:0]);
         tick(2);
         exp_pin.push_back(pins(c, radio_state));
         pin_v = 1;
         tick(1);
         pin_v = 0;
      end
      // status read-back in a live sequence
      radio_state = c[0] ? RFPMSC_ST_TX : RFPMSC_ST_RX;
      tick(2);
      p = pins(c, radio_state);
      st = 16'h0000;
      st[STAT_STATE_LSB +: 3] = radio_state;
      st[STAT_CTRL_OUT_POS] = p[8];
      st[STAT_CTRL_OE_POS] = p[9];
      st[STAT_LNA_SW_POS] = p[7];
      st[STAT_SHARED_PA_POS] = p[6];
      st[STAT_TX_PA_POS] = p[5];
      st[STAT_BIDIR_POS] = p[4];
      rd_chk(RF_STATUS_ADDR, st);
   endtask
   always @(posedge clk_sys)
   begin
      cycles++;
      if (word_v) cmp("word", exp_word.pop_front(), got);
      if (word_v) cmp("miso_oe", exp_sel.pop_front(), {14'h0000, sel_seen});
      if (pin_v) cmp("pins", {6'h00, exp_pin.pop_front()}, pin_w);
      if (cycles == 12000)
      begin
         miscompares++;
         test_done;
      end
   end
   initial
   begin
      logic [15:0] d;
      tick(6);
      resetn = 1;
      tick(3);
      rd_chk(RF_IF_CTRL_ADDR, RF_IF_CTRL_RESET);
      pin_chk(3'h0);
      $display("test reset done");
      for (int i = 0; i < 8; i++)
      begin
         seed = xs(seed);
         d = seed[15:0];
         d[14:12] = i[2:0];
         frame({2'b00, RF_IF_CTRL_ADDR, d}, 24, got);
         rd_chk(RF_IF_CTRL_ADDR, d);
         pin_chk(i[2:0]);
      end
      $display("test modes done");
      frame({2'b00, 6'h05, ~d}, 24, got);
      rd_chk(6'h05, RD_UNMAPPED);
      frame({2'b00, RF_IF_CTRL_ADDR, ~d}, 12, got);
      rd_chk(RF_IF_CTRL_ADDR, d);
      $display("test refusal done");
      resetn = 0;
      tick(2);
      resetn = 1;
      tick(3);
      rd_chk(RF_IF_CTRL_ADDR, RF_IF_CTRL_RESET);
      $display("test rereset done");
      test_done;
   end
endmodule // rf_port_mode_and_switch_ctrl_tb
`default_nettype wire
